/* hdl/lcd_cmd_pkg.sv */
// constants shared by the lcd host command decoder and its address unit
// assumes a single 10 MHz clock domain
package lcd_cmd_pkg;
  localparam logic [7:0] CMD_CURSOR_SET = 8'h21;
  localparam logic [7:0] CMD_OFFSET_SET = 8'h22;
  localparam logic [7:0] CMD_ADDR_SET = 8'h24;
  localparam logic [7:0] CMD_TEXT_HOME = 8'h40;
  localparam logic [7:0] CMD_TEXT_AREA = 8'h41;
  localparam logic [7:0] CMD_GFX_HOME = 8'h42;
  localparam logic [7:0] CMD_GFX_AREA = 8'h43;
  localparam int CURSOR_COL_W = 7;
  localparam int CURSOR_ROW_W = 5;
  localparam int CG_OFFSET_W = 5;
  localparam int CG_CODE_W = 8;
  localparam int CG_LINE_W = 3;
  localparam int CG_OFFSET_LSB = 11;
  localparam int CG_CODE_LSB = 3;
  localparam int EXEC_CYCLES = 4;
  localparam logic [2:0] EXEC_CNT_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
endpackage

/* hdl/cg_addr_gen.sv */
// character generator ram address former
// assumes offset, code and line count are stable in the fetch cycle
`timescale 1ns/100ps
`default_nettype none
module cg_addr_gen
  import lcd_cmd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [CG_OFFSET_W-1:0] cg_offset_address_bits_i,
  input wire logic [CG_CODE_W-1:0] char_code_i,
  input wire logic [CG_LINE_W-1:0] line_cnt_i,
  output logic [15:0] cg_addr_o
);
  logic [15:0] addr_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_ff <= WORD_RST;
    end else begin
      addr_ff <= {cg_offset_address_bits_i, char_code_i, line_cnt_i};
    end
  end
  assign cg_addr_o = addr_ff;
endmodule // cg_addr_gen
`default_nettype wire

/* hdl/lcd_host_command_decoder.sv */
// host command and parameter decoder of a graphic lcd controller
// assumes host strobes synchronous to sys_clk_i; one byte per write pulse
`timescale 1ns/100ps
`default_nettype none
module lcd_host_command_decoder
  import lcd_cmd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cd_i,
  input wire logic [7:0] data_i,
  input wire logic line_end_i,
  input wire logic auto_mode_i,
  input wire logic [CG_CODE_W-1:0] char_code_i,
  input wire logic [CG_LINE_W-1:0] line_cnt_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic [CURSOR_COL_W-1:0] cursor_column_o,
  output logic [CURSOR_ROW_W-1:0] cursor_row_o,
  output logic [CG_OFFSET_W-1:0] cg_offset_o,
  output logic [15:0] addr_ptr_o,
  output logic [15:0] text_base_addr_o,
  output logic [7:0] text_width_columns_o,
  output logic [15:0] gfx_base_addr_o,
  output logic [7:0] gfx_width_columns_o,
  output logic [15:0] cg_addr_o,
  output logic cmd_pending_o,
  output logic cmd_done_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXEC = 3'b100
  } dec_state_t;

  typedef struct packed {
    dec_state_t st;
    logic [7:0] first_parameter;
    logic [7:0] second_parameter;
    logic [7:0] cmd;
    logic [2:0] exec_cnt;
    logic [CURSOR_COL_W-1:0] cursor_column;
    logic [CURSOR_ROW_W-1:0] cursor_row;
    logic [CG_OFFSET_W-1:0] cg_off;
    logic [15:0] addr_ptr;
    logic [15:0] text_base_addr;
    logic [7:0] text_width_columns;
    logic [15:0] gfx_base_addr;
    logic [7:0] gfx_width_columns;
    logic [7:0] rdata;
    logic oe_n;
    logic done;
    logic wr_q;
  } dec_regs_t;

  dec_regs_t cur_ff;
  dec_regs_t nxt_ff;
  logic wr_edge;
  logic rd_stat;
  logic busy;

  function automatic logic is_msb0(input logic [7:0] c);
    is_msb0 = ~c[7];
  endfunction

  assign wr_edge = !ce_n_i && !wr_n_i && !cur_ff.wr_q;
  assign rd_stat = !ce_n_i && !rd_n_i && wr_n_i && cd_i;
  assign busy = (cur_ff.st != ST_IDLE);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wr_q = !ce_n_i && !wr_n_i;
    nxt_ff.done = 1'b0;
    nxt_ff.oe_n = !rd_stat;
    // status: bit0 cmd_ready_flag, bit1 data_rw_ready_flag, bits2/3 auto flags
    nxt_ff.rdata = {4'h0, auto_mode_i & ~busy, auto_mode_i & ~busy, 2'b00};
    if (!auto_mode_i) begin
      nxt_ff.rdata[0] = ~busy;
      nxt_ff.rdata[1] = ~busy;
    end
    unique case (cur_ff.st)
      ST_IDLE: begin
        if (wr_edge && !cd_i) begin
          // older byte shifts out; the last two survive
          nxt_ff.first_parameter = cur_ff.second_parameter;
          nxt_ff.second_parameter = data_i;
        end else if (wr_edge && cd_i) begin
          nxt_ff.cmd = data_i;
          if (is_msb0(data_i) && line_end_i) begin
            nxt_ff.st = ST_WAIT;
          end else begin
            nxt_ff.st = ST_EXEC;
            nxt_ff.exec_cnt = EXEC_CNT_RST;
          end
        end
      end
      ST_WAIT: begin
        // writes here are dropped, so latched parameters stay intact
        if (!line_end_i) begin
          nxt_ff.st = ST_EXEC;
          nxt_ff.exec_cnt = EXEC_CNT_RST;
        end
      end
      ST_EXEC: begin
        nxt_ff.exec_cnt = cur_ff.exec_cnt + 3'h1;
        if (cur_ff.exec_cnt == 3'(EXEC_CYCLES - 1)) begin
          nxt_ff.st = ST_IDLE;
          nxt_ff.done = 1'b1;
          // with two bytes queued, older one is the first parameter
          unique case (cur_ff.cmd)
            CMD_CURSOR_SET: begin
              nxt_ff.cursor_column = cur_ff.first_parameter[CURSOR_COL_W-1:0];
              nxt_ff.cursor_row = cur_ff.second_parameter[CURSOR_ROW_W-1:0];
            end
            CMD_OFFSET_SET: begin
              nxt_ff.cg_off = cur_ff.first_parameter[CG_OFFSET_W-1:0];
            end
            CMD_ADDR_SET: begin
              nxt_ff.addr_ptr = {cur_ff.second_parameter, cur_ff.first_parameter};
            end
            CMD_TEXT_HOME: begin
              // base is the top-left character cell
              nxt_ff.text_base_addr = {cur_ff.second_parameter, cur_ff.first_parameter};
            end
            CMD_TEXT_AREA: begin
              nxt_ff.text_width_columns = cur_ff.first_parameter;
            end
            CMD_GFX_HOME: begin
              nxt_ff.gfx_base_addr = {cur_ff.second_parameter, cur_ff.first_parameter};
            end
            CMD_GFX_AREA: begin
              nxt_ff.gfx_width_columns = cur_ff.first_parameter;
            end
            default: begin
              // other commands belong to neighbouring blocks; cursor untouched
            end
          endcase
        end
      end
      default: begin
        nxt_ff.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_ff <= '{st: ST_IDLE, first_parameter: BYTE_RST, second_parameter: BYTE_RST,
                  cmd: BYTE_RST, exec_cnt: EXEC_CNT_RST, cursor_column: '0,
                  cursor_row: '0, cg_off: '0, addr_ptr: WORD_RST,
                  text_base_addr: WORD_RST, text_width_columns: BYTE_RST,
                  gfx_base_addr: WORD_RST, gfx_width_columns: BYTE_RST,
                  rdata: BYTE_RST, oe_n: 1'b1, done: 1'b0, wr_q: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------
  // cg address
  // ----------------------------------------
  cg_addr_gen u_cg_addr (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .cg_offset_address_bits_i(cur_ff.cg_off),
    .char_code_i(char_code_i),
    .line_cnt_i(line_cnt_i),
    .cg_addr_o(cg_addr_o)
  );

  assign data_o = cur_ff.rdata;
  assign data_oe_n_o = cur_ff.oe_n;
  assign cursor_column_o = cur_ff.cursor_column;
  assign cursor_row_o = cur_ff.cursor_row;
  assign cg_offset_o = cur_ff.cg_off;
  assign addr_ptr_o = cur_ff.addr_ptr;
  assign text_base_addr_o = cur_ff.text_base_addr;
  assign text_width_columns_o = cur_ff.text_width_columns;
  assign gfx_base_addr_o = cur_ff.gfx_base_addr;
  assign gfx_width_columns_o = cur_ff.gfx_width_columns;
  assign cmd_pending_o = (cur_ff.st == ST_WAIT);
  assign cmd_done_o = cur_ff.done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_cmd_in_line_end;
    wr_edge && cd_i && is_msb0(data_i) && line_end_i && !busy;
  endsequence
  sequence s_line_end_held;
    line_end_i [*2];
  endsequence

  chk_pend_on_lineend: assert property (s_cmd_in_line_end |=> cmd_pending_o)
    else $error("msb0 command at line end not held");
  chk_pend_stays: assert property (s_cmd_in_line_end ##1 s_line_end_held |-> cmd_pending_o)
    else $error("pending dropped during line end");
  chk_pend_ignore: assert property (cmd_pending_o && wr_edge && !cd_i
      |=> $stable(cur_ff.second_parameter))
    else $error("byte accepted while pending");
  chk_param_shift: assert property (!busy && wr_edge && !cd_i
      |=> cur_ff.second_parameter == $past(data_i)
          && cur_ff.first_parameter == $past(cur_ff.second_parameter))
    else $error("parameter queue wrong");
  chk_exec_length: assert property (!busy && wr_edge && cd_i && !line_end_i
      |-> ##(EXEC_CYCLES + 1) cmd_done_o)
    else $error("command did not finish on time");
  chk_cursor_load: assert property (cmd_done_o && cur_ff.cmd == CMD_CURSOR_SET
      |-> cursor_column_o == cur_ff.first_parameter[CURSOR_COL_W-1:0]
          && cursor_row_o == cur_ff.second_parameter[CURSOR_ROW_W-1:0])
    else $error("cursor load wrong");
  chk_cursor_still: assert property (!(cmd_done_o && cur_ff.cmd == CMD_CURSOR_SET)
      |-> $stable(cursor_column_o) && $stable(cursor_row_o))
    else $error("cursor moved without load");
  chk_addr_ptr: assert property (cmd_done_o && cur_ff.cmd == CMD_ADDR_SET
      |-> addr_ptr_o == {cur_ff.second_parameter, cur_ff.first_parameter})
    else $error("address pointer wrong");
  chk_cg_window: assert property (##1 cg_addr_o == {$past(cg_offset_o),
      $past(char_code_i), $past(line_cnt_i)})
    else $error("cg address wrong");
  chk_offset_load: assert property (cmd_done_o && cur_ff.cmd == CMD_OFFSET_SET
      |-> cg_offset_o == cur_ff.first_parameter[CG_OFFSET_W-1:0])
    else $error("offset load wrong");
endmodule // lcd_host_command_decoder
`default_nettype wire

/* testbench/lcd_host_model.sv */
// behavioural host microprocessor on the 8-bit parallel port
// assumes the decoder's registered status answer and strobes sampled on sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] status_i,
  input wire logic status_oe_n_i,
  input wire logic auto_mode_i,
  output logic ce_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cd_o,
  output logic [7:0] data_o
);
  initial begin
    ce_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cd_o = 1'b1;
    data_o = 8'h00;
  end
  // one byte per low write pulse; released lines show the inverse so stale data cannot pass
  task automatic put(input logic c, input logic [7:0] d);
    @(posedge sys_clk_i);
    #10 ce_n_o = 1'b0;
    wr_n_o = 1'b0;
    cd_o = c;
    data_o = d;
    @(posedge sys_clk_i);
    #10 ce_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = ~d;
  endtask
  task automatic poll();
    logic ok;
    ok = 1'b0;
    repeat (60) if (!ok) begin
      @(posedge sys_clk_i);
      #10 ce_n_o = 1'b0;
      rd_n_o = 1'b0;
      cd_o = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #10 ok = (status_oe_n_i === 1'b0) &&
        (auto_mode_i ? status_i[3:2] === 2'b11 : status_i[1:0] === 2'b11);
      ce_n_o = 1'b1;
      rd_n_o = 1'b1;
    end
  endtask
  task automatic param(input logic [7:0] p);
    poll();
    put(1'b0, p);
  endtask
  task automatic send(input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] c);
    param(p1);
    param(p2);
    poll();
    put(1'b1, c);
  endtask
endmodule // lcd_host_model
`default_nettype wire

/* testbench/test_lcd_host_command_decoder.sv */
// self-checking bench of the host command decoder
// assumes the host model drives the port; completions are judged on cmd_done_o
`timescale 1ns/100ps
`default_nettype none
module test_lcd_host_command_decoder;
  import lcd_cmd_pkg::*;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
  typedef struct packed {logic [7:0] c; logic [15:0] v;} note_t;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, line_end_i = 1'b0, auto_mode_i = 1'b0;
  logic ce_n, rd_n, wr_n, cd;
  logic [7:0] wdata, data_o, text_width_columns_o, gfx_width_columns_o;
  logic [7:0] char_code_i = 8'h00;
  logic [2:0] line_cnt_i = 3'h0;
  logic data_oe_n_o, cmd_pending_o, cmd_done_o;
  logic [6:0] cursor_column_o;
  logic [4:0] cursor_row_o, cg_offset_o;
  logic [15:0] addr_ptr_o, text_base_addr_o, gfx_base_addr_o, cg_addr_o, r = 16'd15687, cur;
  logic [15:0] got, want;
  int n_errors = 0, checks_done = 0;
  note_t exp_q[$];
  logic [7:0] cmds[7] = '{CMD_CURSOR_SET, CMD_OFFSET_SET, CMD_ADDR_SET, CMD_TEXT_HOME,
    CMD_TEXT_AREA, CMD_GFX_HOME, CMD_GFX_AREA};
  always #50 sys_clk_i = ~sys_clk_i;
  lcd_host_model host (.sys_clk_i(sys_clk_i), .status_i(data_o), .status_oe_n_i(data_oe_n_o),
    .auto_mode_i(auto_mode_i), .ce_n_o(ce_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .cd_o(cd),
    .data_o(wdata));
  lcd_host_command_decoder uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_n_i(ce_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .cd_i(cd), .data_i(wdata), .line_end_i(line_end_i),
    .auto_mode_i(auto_mode_i), .char_code_i(char_code_i), .line_cnt_i(line_cnt_i),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .cursor_column_o(cursor_column_o),
    .cursor_row_o(cursor_row_o), .cg_offset_o(cg_offset_o), .addr_ptr_o(addr_ptr_o),
    .text_base_addr_o(text_base_addr_o), .text_width_columns_o(text_width_columns_o),
    .gfx_base_addr_o(gfx_base_addr_o), .gfx_width_columns_o(gfx_width_columns_o),
    .cg_addr_o(cg_addr_o), .cmd_pending_o(cmd_pending_o), .cmd_done_o(cmd_done_o));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] seen(input logic [7:0] c);
    case (c)
      CMD_CURSOR_SET: return {4'h0, cursor_row_o, cursor_column_o};
      CMD_OFFSET_SET: return {11'h000, cg_offset_o};
      CMD_ADDR_SET: return addr_ptr_o;
      CMD_TEXT_HOME: return text_base_addr_o;
      CMD_GFX_HOME: return gfx_base_addr_o;
      CMD_TEXT_AREA: return {8'h00, text_width_columns_o};
      default: return {8'h00, gfx_width_columns_o};
    endcase
  endfunction
  // -------------------------------------------------------------
  // result watcher: oldest note against each completion
  // -------------------------------------------------------------
  always @(negedge sys_clk_i) begin
    if (cmd_done_o === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        // pop once into a variable so a mismatch report cannot pop a second note
        got = seen(exp_q[0].c);
        want = exp_q.pop_front().v;
        `CHK(got, want)
      end
    end
  end
  task automatic wait_done();
    int k = 0;
    while (exp_q.size() != 0 && k < 60) begin
      @(posedge sys_clk_i);
      k++;
    end
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("unexpected at %0t: command never completed", $time);
      exp_q.delete();
    end
  endtask
  task automatic issue(input logic [7:0] c, input logic [7:0] p1, input logic [7:0] p2);
    logic [15:0] v;
    case (c)
      CMD_CURSOR_SET: v = {4'h0, p2[4:0], p1[6:0]};
      CMD_OFFSET_SET: v = {11'h000, p1[4:0]};
      CMD_TEXT_AREA, CMD_GFX_AREA: v = {8'h00, p1};
      default: v = {p2, p1};
    endcase
    exp_q.push_back('{c, v});
    host.send(p1, p2, c);
    wait_done();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #5_000_000 n_errors++;
    conclude();
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #10 rstn_i = 1'b1;
    `CHK({addr_ptr_o, text_base_addr_o, cg_offset_o, cmd_pending_o, data_oe_n_o}, 39'h1)
    $display("test reset done");
    foreach (cmds[i]) begin
      r = lfsr(r);
      issue(cmds[i], r[7:0], (cmds[i] inside {CMD_OFFSET_SET, CMD_TEXT_AREA, CMD_GFX_AREA})
        ? 8'h00 : r[15:8]);
      if (i == 0) cur = {4'h0, r[12:8], r[6:0]};
    end
    `CHK(seen(CMD_CURSOR_SET), cur)
    $display("test command table done");
    host.param(8'h5a);
    issue(CMD_ADDR_SET, 8'h3c, 8'hc3);
    $display("test extra parameter done");
    for (int i = 0; i < 3; i++) begin
      r = lfsr(r);
      issue(CMD_OFFSET_SET, i == 0 ? 8'h1f : {3'h0, r[4:0]}, 8'h00);
      #10 char_code_i = i == 0 ? 8'hff : r[12:5];
      line_cnt_i = i == 0 ? 3'h7 : r[15:13];
      repeat (2) @(posedge sys_clk_i);
      `CHK(cg_addr_o, {i == 0 ? 5'h1f : r[4:0], char_code_i, line_cnt_i})
    end
    $display("test cg address done");
    host.param(8'h11);
    host.param(8'h22);
    host.poll();
    #10 line_end_i = 1'b1;
    exp_q.push_back('{CMD_TEXT_HOME, 16'h2211});
    host.put(1'b1, CMD_TEXT_HOME);
    repeat (2) @(posedge sys_clk_i);
    `CHK(cmd_pending_o, 1'b1)
    host.put(1'b0, 8'hee);
    `CHK(cmd_done_o, 1'b0)
    #10 line_end_i = 1'b0;
    wait_done();
    $display("test line end done");
    #10 auto_mode_i = 1'b1;
    host.poll();
    `CHK(data_o[3:2], 2'b11)
    $display("test auto status done");
    conclude();
  end
endmodule // test_lcd_host_command_decoder
`default_nettype wire
